// File: pkg/dma_hs_pkg.sv
// Constants for the disk DMA request handshake block.
// Assumes one 125 MHz clock and a classic Wishbone register slave.
package dma_hs_pkg;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int GAP_MIN_NS = 300;
    localparam int GAP_MAX_NS = 400;
    localparam int GAP_MIN_CYC = (GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_MAX_CYC = GAP_MAX_NS / CLK_PERIOD_NS;
    localparam int GAP_CYC = GAP_MIN_CYC;
    localparam int BYTES_PER_PERIOD = 8;
    localparam int SECTOR_BYTES = 512;
    localparam int ICP_COUNT = 16;
    // Byte period in clocks for each data rate: 1M, 500k, 300k, 250k.
    localparam logic [15:0] BYTE_CYC_1M = 16'h03e8;
    localparam logic [15:0] BYTE_CYC_500K = 16'h07d0;
    localparam logic [15:0] BYTE_CYC_300K = 16'h0d05;
    localparam logic [15:0] BYTE_CYC_250K = 16'h0fa0;
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CMD = 4'h8;
    localparam int CTRL_DMA_BIT = 0;
    localparam int CTRL_FIFO_BIT = 1;
    localparam int CTRL_BURST_DIS_BIT = 2;
    localparam int CTRL_VERIFY_BIT = 3;
    localparam int CTRL_WRITE_BIT = 4;
    localparam int CTRL_RATE_LSB = 8;
    localparam int CTRL_FIFO_THRESHOLD_LEVEL_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_GAP = 2'b10,
        ST_WAIT = 2'b11
    } req_state_t;
endpackage

// File: pkg/pace_if.sv
// Interface between the request engine and its pacing timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface pace_if;
    logic load;
    logic [23:0] count;
    logic done;
    modport engine (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface

// File: src/dma_request_hs.sv
// Disk controller DMA request and acknowledge handshake with Wishbone registers.
// Assumes host inputs are synchronous levels and a classic Wishbone master.
// What this block does
// R01 - Burst or no FIFO: requests start at least eight byte periods apart.
// R02 - Non-burst FIFO: request dropped between transfers for 300 to 400 ns.
// R03 - Acknowledge active edge withdraws the request.
// R04 - Read or write strobe active edge during DMA withdraws the request.
// R05 - Strobes count as DMA accesses only while acknowledge is active.
// R06 - Terminal count active edge withdraws the request.
// R07 - Host finishes each strobe within the service window after a request.
// R08 - Host raises terminal count within the same service window.
// R09 - Nonzero threshold adds threshold times eight byte periods to timing.
// R10 - Host raises terminal count with acknowledge during the final byte.
// R11 - Burst-disable bit selects non-burst behaviour only with FIFO enabled.
// R12 - Transfer-mode bit selects DMA handshake instead of programmed transfers.
// R13 - Configure bits enable the FIFO and load its threshold.
// R14 - FIFO defaults to burst; non-burst pulses request during a burst.
// R15 - Verify transfers accept acknowledge without read strobe as done.
// R16 - Write or format drops request when a sector's last byte arrives.
// R17 - Acknowledge, strobes and terminal count are synchronised first.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module dma_request_hs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic dack_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic tc,
    output logic drq,
    output logic int_req
);
    import dma_hs_pkg::*;

    // -----------------------------------------------------------------
    // Register bus
    // -----------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [9:0] byte_cnt_r;
    logic active_r;
    logic tc_seen_r;
    req_state_t state_r;
    req_state_t state_nxt;
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    wire bus_wr = bus_req && wb_we_i;
    wire sel_ctrl = (wb_adr_i[3:0] == ADDR_CTRL);
    wire sel_status = (wb_adr_i[3:0] == ADDR_STATUS);
    wire sel_cmd = (wb_adr_i[3:0] == ADDR_CMD);
    wire cmd_start = bus_wr && sel_cmd && wb_sel_i[0] && wb_dat_i[CMD_START_BIT];
    wire cmd_stop = bus_wr && sel_cmd && wb_sel_i[0] && wb_dat_i[CMD_STOP_BIT];
    wire [31:0] status_word = {17'h00000, byte_cnt_r, tc_seen_r, drq,
                               state_r, active_r};
    wire [31:0] read_mux = sel_ctrl ? ctrl_r : (sel_status ? status_word : 32'h0000_0000);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // R13 configure write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RESET;
        end else if (bus_wr && sel_ctrl) begin
            ctrl_r <= merge_bytes(ctrl_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            rdata_r <= bus_req ? read_mux : rdata_r;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // -----------------------------------------------------------------
    // Configuration decode
    // -----------------------------------------------------------------
    // R12 transfer mode
    wire dma_mode = ctrl_r[CTRL_DMA_BIT];
    // R13 fifo enable
    wire fifo_en = ctrl_r[CTRL_FIFO_BIT];
    wire burst_disable_bit = ctrl_r[CTRL_BURST_DIS_BIT];
    wire verify_op = ctrl_r[CTRL_VERIFY_BIT];
    wire write_op = ctrl_r[CTRL_WRITE_BIT];
    wire [1:0] rate_sel = ctrl_r[CTRL_RATE_LSB +: 2];
    wire [3:0] fifo_threshold_level = ctrl_r[CTRL_FIFO_THRESHOLD_LEVEL_LSB +: 4];
    // R11 non-burst select
    wire non_burst = fifo_en && burst_disable_bit;
    // R14 burst default
    wire burst_mode = fifo_en && !burst_disable_bit;

    // A table keeps the rates free of a divider, at the cost of a fixed set of four.
    function automatic logic [15:0] rate_byte_cycles(input logic [1:0] rate);
        logic [15:0] cyc;
        unique case (rate)
            2'h0: cyc = BYTE_CYC_500K;
            2'h1: cyc = BYTE_CYC_300K;
            2'h2: cyc = BYTE_CYC_250K;
            2'h3: cyc = BYTE_CYC_1M;
        endcase
        return cyc;
    endfunction
    wire [15:0] byte_cyc = rate_byte_cycles(rate_sel);
    // R01 eight byte periods
    // R09 threshold extension
    wire [23:0] unit_cyc = {8'h00, byte_cyc} * 24'(BYTES_PER_PERIOD);
    wire [23:0] period_cyc = unit_cyc + unit_cyc * {20'h00000, fifo_threshold_level};

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] prev_r;
    // R17 two-stage sync
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Reset to the idle pin levels so that no false edge follows reset.
            sync1_r <= 4'h7;
            sync2_r <= 4'h7;
            prev_r <= 4'h7;
        end else begin
            sync1_r <= {tc, wr_n, rd_n, dack_n};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end
    wire dack_act = !sync2_r[0];
    wire dack_edge = !sync2_r[0] && prev_r[0];
    // R05 strobe qualified
    wire rd_edge = dack_act && !sync2_r[1] && prev_r[1];
    wire wr_edge = dack_act && !sync2_r[2] && prev_r[2];
    wire tc_edge = sync2_r[3] && !prev_r[3];
    wire dack_rise = sync2_r[0] && !prev_r[0];
    // R15 verify acknowledge alone
    wire xfer_done = verify_op ? dack_rise : (rd_edge || wr_edge);
    // R03 R04 R06 withdraw
    wire withdraw = dack_edge || rd_edge || wr_edge || tc_edge;

    // -----------------------------------------------------------------
    // Request engine
    // -----------------------------------------------------------------
    pace_if pace ();
    pace_timer u_pace (
        .clk(clk),
        .sys_rst(sys_rst),
        .pace(pace)
    );
    logic [5:0] gap_r;
    wire last_byte = (byte_cnt_r == 10'(SECTOR_BYTES - 1));
    // R01 paced modes
    // Non-burst is spaced only by its short gap, which keeps that gap under its ceiling.
    wire paced = burst_mode || !fifo_en;
    wire pace_ok = !paced || pace.done;
    wire gap_done = (gap_r == 6'(GAP_CYC - 1));

    always_comb begin
        state_nxt = state_r;
        pace.load = 1'b0;
        pace.count = period_cyc;
        unique case (state_r)
            ST_IDLE: begin
                if (active_r && dma_mode && pace_ok) begin
                    state_nxt = ST_REQ;
                    pace.load = 1'b1;
                end
            end
            ST_REQ: begin
                if (withdraw || (verify_op && xfer_done)) begin
                    // R02 non-burst gap
                    state_nxt = non_burst ? ST_GAP : ST_WAIT;
                end
            end
            ST_GAP: begin
                if (gap_done) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!active_r) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // R02 gap length
    // The counter restarts on every entry, so one counter serves all transfers.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_r <= 6'h00;
        end else if (state_r == ST_GAP) begin
            gap_r <= gap_r + 6'h01;
        end else begin
            gap_r <= 6'h00;
        end
    end

    // -----------------------------------------------------------------
    // Byte counter and run control
    // -----------------------------------------------------------------
    // Terminal count ends the run before the host lets go of its final byte,
    // so that byte is still owed to the counter until it completes.
    logic tail_r;
    wire count_ok = active_r || tail_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tail_r <= 1'b0;
        end else if (tc_edge && !xfer_done) begin
            tail_r <= 1'b1;
        end else if (xfer_done || cmd_start) begin
            tail_r <= 1'b0;
        end
    end

    // R16 sector byte counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_cnt_r <= 10'h000;
        end else if (cmd_start) begin
            byte_cnt_r <= 10'h000;
        end else if (xfer_done && count_ok) begin
            byte_cnt_r <= last_byte ? 10'h000 : byte_cnt_r + 10'h001;
        end
    end

    // R16 last byte ends write
    // Terminal count or the sector's last byte on a write ends the run.
    wire run_end = tc_edge || (write_op && xfer_done && last_byte);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_r <= 1'b0;
        end else if (cmd_start) begin
            active_r <= 1'b1;
        end else if (run_end || cmd_stop) begin
            active_r <= 1'b0;
        end
    end

    // Set wins over the clear from a new start.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tc_seen_r <= 1'b0;
        end else if (tc_edge) begin
            tc_seen_r <= 1'b1;
        end else if (cmd_start) begin
            tc_seen_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Request outputs
    // -----------------------------------------------------------------
    // Programmed mode signals via interrupt rather than the DMA request.
    wire req_level = (state_r == ST_REQ);
    wire drq_nxt = (state_nxt == ST_REQ) && dma_mode;
    wire int_req_nxt = active_r && !dma_mode && !req_level;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            drq <= 1'b0;
            int_req <= 1'b0;
        end else begin
            drq <= drq_nxt;
            int_req <= int_req_nxt;
        end
    end
endmodule

// File: src/pace_timer.sv
// Down counter that paces request assertions.
// Assumes load is a one-cycle pulse from the engine.
`timescale 1ns/1ns
module pace_timer (
    input wire logic clk,
    input wire logic sys_rst,
    pace_if.timer pace
);
    logic [23:0] cnt_r;
    assign pace.done = (cnt_r == 24'h000000);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 24'h000000;
        end else if (pace.load) begin
            cnt_r <= pace.count;
        end else if (cnt_r != 24'h000000) begin
            cnt_r <= cnt_r - 24'h000001;
        end
    end
endmodule

// File: tb/dma_host_model.sv
// Behavioural host DMA controller that serves each request.
// Assumes drq is a registered level in the clk domain.
`timescale 1ns/1ns
module dma_host_model (
    input wire logic clk,
    input wire logic drq,
    input wire logic en,
    input wire logic verify,
    input wire logic stray,
    input wire logic wr_op,
    input wire logic [31:0] tc_at,
    output logic dack_n,
    output logic rd_n,
    output logic wr_n,
    output logic tc,
    output int n
);
    initial begin
        {dack_n, rd_n, wr_n, tc} = 4'he;
        n = 0;
        forever begin
            @(posedge clk);
            if (en && drq === 1'b1) begin
                if (stray) begin
                    rd_n <= 1'b0;
                    repeat (2) @(posedge clk);
                    rd_n <= 1'b1;
                    repeat (6) @(posedge clk);
                end
                repeat (2) @(posedge clk);
                dack_n <= 1'b0;
                @(posedge clk);
                rd_n <= verify || wr_op;
                wr_n <= verify || !wr_op;
                tc <= (n + 1 == tc_at);
                repeat (7) @(posedge clk);
                rd_n <= 1'b1;
                wr_n <= 1'b1;
                tc <= 1'b0;
                @(posedge clk);
                dack_n <= 1'b1;
                n <= n + 1;
                repeat (2) @(posedge clk);
            end
        end
    end
endmodule

// File: tb/dma_hs_asserts.sv
// Assertions on the request pins of dma_request_hs.
// Assumes full-word CTRL writes, so byte enables are not tracked.
`timescale 1ns/1ns
module dma_hs_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic dack_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic tc,
    input wire logic drq,
    input wire logic int_req
);
    import dma_hs_pkg::*;
    logic [31:0] ctrl_r;
    logic [31:0] per_r;
    logic [7:0] low_r;
    logic drq_q_r;
    wire wr_ack = wb_ack_o && wb_we_i;
    wire [1:0] rate = ctrl_r[9:8];
    wire [3:0] thr = ctrl_r[19:16];
    wire [15:0] bc = rate == 2'h0 ? BYTE_CYC_500K : rate == 2'h1 ? BYTE_CYC_300K :
        rate == 2'h2 ? BYTE_CYC_250K : BYTE_CYC_1M;
    wire [31:0] per_min = 32'(bc) * 32'(BYTES_PER_PERIOD) * (32'(thr) + 32'h1);
    wire paced = !ctrl_r[CTRL_FIFO_BIT] || !ctrl_r[CTRL_BURST_DIS_BIT];
    wire nb = ctrl_r[CTRL_FIFO_BIT] && ctrl_r[CTRL_BURST_DIS_BIT];
    // A new run may request at once, so a start clears the period history.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RESET;
            per_r <= 32'hffff_ffff;
            low_r <= 8'hff;
            drq_q_r <= 1'b0;
        end else begin
            drq_q_r <= drq;
            if (wr_ack && wb_adr_i[3:0] == ADDR_CMD) begin
                low_r <= 8'hff;
            end else if (drq) begin
                low_r <= 8'h0;
            end else if (low_r != 8'hff) begin
                low_r <= low_r + 8'h1;
            end
            if (wr_ack && wb_adr_i[3:0] == ADDR_CTRL) begin
                ctrl_r <= wb_dat_i;
            end
            if (wr_ack && wb_adr_i[3:0] == ADDR_CMD) begin
                per_r <= 32'hffff_ffff;
            end else if (drq && !drq_q_r) begin
                per_r <= 32'h1;
            end else if (per_r != 32'hffff_ffff) begin
                per_r <= per_r + 32'h1;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence ack_edge_s;
        $fell(dack_n) && drq;
    endsequence
    sequence drop_s;
        ##[1:6] !drq;
    endsequence
    dack_drop_a: assert property (ack_edge_s |-> drop_s)
        else $error("request held after acknowledge edge");
    strobe_drop_a: assert property (($fell(rd_n) || $fell(wr_n)) && !dack_n && drq |-> drop_s)
        else $error("request held after strobe edge");
    tc_drop_a: assert property ($rose(tc) && drq |-> drop_s)
        else $error("request held after terminal count");
    strobe_ignored_a: assert property ($fell(rd_n) && dack_n && drq |=> drq [*6])
        else $error("strobe without acknowledge dropped request");
    sync_delay_a: assert property (ack_edge_s |=> drq)
        else $error("acknowledge used without synchronising");
    nb_gap_a: assert property (nb && $rose(drq) |-> low_r >= 8'(GAP_MIN_CYC))
        else $error("non-burst gap too short");
    nb_gap_max_a: assert property (nb && $rose(drq) && low_r != 8'hff |->
        low_r <= 8'(GAP_MAX_CYC))
        else $error("non-burst gap too long");
    period_a: assert property (paced && thr == 4'h0 && $rose(drq) |-> per_r >= per_min)
        else $error("request period too short");
    fifo_threshold_level_period_a: assert property (paced && thr != 4'h0 && $rose(drq) |-> per_r >= per_min)
        else $error("threshold period too short");
    pio_mode_a: assert property (int_req |-> !drq && !ctrl_r[CTRL_DMA_BIT])
        else $error("request raised in programmed mode");
endmodule

bind dma_request_hs dma_hs_asserts u_chk (.clk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .dack_n, .rd_n, .wr_n, .tc, .drq,
    .int_req);

// File: tb/tb.sv
// Self-checking bench for dma_request_hs with a host DMA model.
// Assumes the 1 Mb/s rate, so a paced request takes 8000 clocks at threshold zero.
`timescale 1ns/1ns
module tb;
    import dma_hs_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, q;
    logic we = 1'b0, stb = 1'b0, en = 1'b0, verify = 1'b0, stray = 1'b0, wr_op = 1'b0;
    logic ack, drq, int_req, dack_n, rd_n, wr_n, tc;
    int tc_at = 0, n, n_mismatch = 0, comparisons = 0;
    dma_request_hs uut (.clk, .sys_rst, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_ack_o(ack),
        .dack_n, .rd_n, .wr_n, .tc, .drq, .int_req);
    dma_host_model host (.clk, .drq, .en, .verify, .stray, .wr_op, .tc_at, .dack_n, .rd_n,
        .wr_n, .tc, .n);
    initial forever #4 clk = ~clk;
    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        n_mismatch++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad("value mismatch");
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk);
        adr <= {28'h0, a};
        wdat <= d;
        we <= w;
        stb <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        if (i >= 50) begin
            bad("bus hang");
            final_report();
        end
        q = rdat;
        stb <= 1'b0;
    endtask
    task automatic wait_n(input int k, input int lim);
        for (int i = 0; i < lim && n < k; i++) begin
            @(posedge clk);
        end
        if (n < k) begin
            bad("transfer timeout");
            final_report();
        end
    endtask
    task automatic s_regs();
        wb(ADDR_CTRL, 1'b0, 32'h0);
        chk(q, CTRL_RESET);
        wb(4'hc, 1'b1, 32'hffff_ffff);
        wb(4'hc, 1'b0, 32'h0);
        chk(q, 32'h0);
        wb(ADDR_CTRL, 1'b1, 32'h0005_0303);
        wb(ADDR_CTRL, 1'b0, 32'h0);
        chk(q, 32'h0005_0303);
    endtask
    task automatic s_pio();
        wb(ADDR_CTRL, 1'b1, 32'h0000_0300);
        wb(ADDR_CMD, 1'b1, 32'h1);
        repeat (3) @(posedge clk);
        chk({30'h0, int_req, drq}, 32'h2);
        wb(ADDR_CMD, 1'b1, 32'h2);
        repeat (3) @(posedge clk);
        chk({30'h0, int_req, drq}, 32'h0);
    endtask
    task automatic s_run(input logic [31:0] c, input int k, input int lim);
        en <= 1'b1;
        wb(ADDR_CTRL, 1'b1, c);
        wb(ADDR_CMD, 1'b1, 32'h1);
        wait_n(n + k, lim);
        repeat (8) @(posedge clk);
        chk({31'h0, drq}, 32'h0);
    endtask
    task automatic s_paced();
        s_run(32'h0000_0301, 3, 30000);
        wb(ADDR_CMD, 1'b1, 32'h2);
        stray <= 1'b1;
        s_run(32'h0001_0307, 2, 40000);
        wb(ADDR_CMD, 1'b1, 32'h2);
        stray <= 1'b0;
        s_run(32'h0001_0303, 2, 40000);
        wb(ADDR_CMD, 1'b1, 32'h2);
    endtask
    task automatic s_write();
        int n0;
        n0 = n;
        wr_op <= 1'b1;
        s_run(32'h0000_0317, 512, 30000);
        repeat (60) @(posedge clk);
        chk(32'(n - n0), 32'h0000_0200);
        wb(ADDR_STATUS, 1'b0, 32'h0);
        chk({17'h0, q[14:0]}, 32'h0);
        wr_op <= 1'b0;
    endtask
    task automatic s_verify();
        verify <= 1'b1;
        tc_at <= n + 4;
        s_run(32'h0000_030f, 4, 3000);
        wb(ADDR_STATUS, 1'b0, 32'h0);
        chk({21'h0, q[14:4]}, 32'h9);
        wb(ADDR_CMD, 1'b1, 32'h2);
        en <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        s_regs();
        s_pio();
        s_paced();
        s_write();
        s_verify();
        final_report();
    end
endmodule
